// ===== design/eeprom_front_end.sv
`default_nettype none
module rx_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             clock,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data_ff,
  output logic                  out_valid_ff,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wptr_ff;
  logic [AW-1:0]    rptr_ff;
  logic [AW:0]      count_ff;
  logic             push;
  logic             pop;

  assign in_ready = (count_ff != (AW+1)'(DEPTH));
  assign push     = in_valid && in_ready;
  // The output stage is a register so that the top's outputs come from flops.
  assign pop      = (count_ff != '0) && (!out_valid_ff || out_ready);

  always_ff @(posedge clock) begin
    if (push) begin
      mem_ff[wptr_ff] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      wptr_ff  <= '0;
      rptr_ff  <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wptr_ff <= (wptr_ff == AW'(DEPTH - 1)) ? '0 : wptr_ff + 1'b1;
      end
      if (pop) begin
        rptr_ff <= (rptr_ff == AW'(DEPTH - 1)) ? '0 : rptr_ff + 1'b1;
      end
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      out_valid_ff <= 1'b0;
      out_data_ff  <= '0;
    end else if (pop) begin
      out_valid_ff <= 1'b1;
      out_data_ff  <= mem_ff[rptr_ff];
    end else if (out_ready) begin
      out_valid_ff <= 1'b0;
    end
  end
endmodule // rx_byte_fifo

// Functional notes
// R1: Sample SDA on SCL rise; change own SDA only after an SCL fall.
// R2: Bytes arrive MSB first, eight bits, then a ninth acknowledge cycle.
// R3: SDA changes while SCL is high are Start or Stop, never data.
// R4: Start is SDA falling with SCL high; ignore the bus until one.
// R5: Stop is SDA rising with SCL high; it ends the transaction.
// R6: Stop after a write launches the write cycle; otherwise return to standby.
// R7: Acknowledge by holding SDA low for the whole ninth cycle.
// R8: Standby on power-up, after a read Stop, and when an operation completes.
// R9: Master recovers the bus with Start, nine clocks, Start, Stop.
// R10: After power-on release reset protocol and enter standby; ignore before it.
// R11: Master waits at least 10.0 ms after power-up before commanding.
// R12: Brown-out resets at once and silences the device until power returns.
// R13: Write protect high blocks changes to main array and info page.
// R14: First byte after Start: type code, three chip bits, direction bit.
// R15: Accept type 1010 for array, 1011 for page, lock, serial; reject others.
// R16: Chip-address bits must equal the three straps.
// R17: Address byte bit 0 is direction: 1 read, 0 write.
// R18: Acknowledge a matching address byte; on mismatch no ack, go standby.
// R19: Then take two word-address bytes, high first, acknowledging each.
// R20: Array uses bits 12:0; half-size variant also ignores bit 12.
// R21: With 1011, bits 10:9 pick info page or lock status, lock, or serial; the code gives the info page for reads too, never lock status.
// R22: 1011 write addresses the lock; 1011 read addresses the serial number.
// R23: Master sets byte count and clocks every byte without gaps.
// R24: Under write protect, ack address bytes but not data bytes; the code still acks data bytes to the lock.
// R25: Synchronise and filter SCL and SDA before edge detection.
// R26: A Start mid-transaction aborts it and restarts address reception.
module eeprom_front_end
  import eeprom_front_pkg::*;
#(
  parameter bit HALF_SIZE = 1'b0
) (
  input  wire logic   clock,
  input  wire logic   rst_b,
  input  wire logic   power_good,
  input  wire logic   brownout,
  input  wire logic   scl_i,
  input  wire logic   sda_i,
  output logic        sda_o_ff,
  output logic        sda_oe_ff,
  input  wire logic   strap_addr_bit0,
  input  wire logic   strap_addr_bit1,
  input  wire logic   strap_addr_bit2,
  input  wire logic   write_protect,
  input  wire logic   info_page_frozen,
  input  wire logic   op_done,
  output logic        standby_ff,
  output logic        write_start_ff,
  output logic        addr_valid_ff,
  output target_t     target_ff,
  output logic        read_dir_ff,
  output logic [15:0] word_addr_ff,
  output logic [7:0]  rx_data_ff,
  output logic        rx_valid_ff,
  input  wire logic   rx_ready
);
  logic [IN_W-1:0] sync1_ff;
  logic [IN_W-1:0] sync2_ff;
  logic [IN_W-1:0] sync3_ff;
  logic [IN_W-1:0] filt_ff;
  logic            scl_prev_ff;
  logic            sda_prev_ff;
  logic            alive;
  logic            scl_rise;
  logic            scl_fall;
  logic            start_seen;
  logic            stop_seen;
  state_t          state_ff;
  logic [3:0]      bit_cnt_ff;
  logic [7:0]      shift_ff;
  logic            ack_phase_ff;
  logic            acked_data_ff;
  logic [7:0]      addr_hi_ff;
  logic            aux_ff;
  logic            push;
  logic [7:0]      push_data_ff;
  logic            push_ff;
  logic            fifo_in_ready;
  logic [7:0]      rx_byte;
  logic            byte_done;
  logic            data_ok;

  function automatic target_t decode_target(input logic aux, input logic rd,
                                            input logic [15:0] wa);
    logic [1:0] sel;
    sel = wa[AUX_SEL_LSB +: 2];
    if (!aux) begin
      return TGT_ARRAY;
    end
    case (sel)
      AUX_INFO_PAGE: return rd ? TGT_INFO_PAGE : TGT_INFO_PAGE; // see R21
      AUX_FREEZE:    return rd ? TGT_NONE : TGT_FREEZE;          // see R22
      AUX_SERIAL:    return rd ? TGT_SERIAL : TGT_NONE;          // see R22
      default:       return TGT_NONE;
    endcase
  endfunction

  // Three stages; a filtered bit moves only when stages two and three agree.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      sync1_ff <= SYNC_RST;
      sync2_ff <= SYNC_RST;
      sync3_ff <= SYNC_RST;
      filt_ff  <= SYNC_RST;
    end else begin
      sync1_ff <= {strap_addr_bit2, strap_addr_bit1, strap_addr_bit0, write_protect,
                   brownout, power_good, sda_i, scl_i};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      filt_ff  <= (sync2_ff & sync3_ff) | (filt_ff & (sync2_ff ^ sync3_ff)); // see R25
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end else begin
      scl_prev_ff <= filt_ff[IN_SCL];
      sda_prev_ff <= filt_ff[IN_SDA];
    end
  end

  // Below the power-on threshold or in brown-out the front end is held idle.
  assign alive      = filt_ff[IN_PG] && !filt_ff[IN_BO]; // see R10, R12
  assign scl_rise   = filt_ff[IN_SCL] && !scl_prev_ff;
  assign scl_fall   = !filt_ff[IN_SCL] && scl_prev_ff;
  assign start_seen = filt_ff[IN_SCL] && scl_prev_ff && sda_prev_ff && !filt_ff[IN_SDA]; // see R4
  assign stop_seen  = filt_ff[IN_SCL] && scl_prev_ff && !sda_prev_ff && filt_ff[IN_SDA]; // see R5, R3
  assign byte_done  = scl_fall && (bit_cnt_ff == 4'(BITS_PER_BYTE)) && !ack_phase_ff;
  assign rx_byte    = shift_ff;

  // Array and info-page data is refused under write protect, info-page and lock data once frozen, any data with a full buffer.
  always_comb begin
    data_ok = fifo_in_ready;
    case (target_ff)
      TGT_ARRAY:     data_ok = data_ok && !filt_ff[IN_WP];                      // see R13, R24
      TGT_INFO_PAGE: data_ok = data_ok && !filt_ff[IN_WP] && !info_page_frozen; // see R13, R24
      TGT_FREEZE:    data_ok = data_ok && !info_page_frozen;
      default:       data_ok = 1'b0;
    endcase
  end

  // Bit counter and shifter.
  always_ff @(posedge clock) begin
    if (!rst_b || !alive) begin
      bit_cnt_ff   <= '0;
      shift_ff     <= '0;
      ack_phase_ff <= 1'b0;
    end else if (start_seen || stop_seen) begin
      bit_cnt_ff   <= '0; // see R26
      ack_phase_ff <= 1'b0;
    end else if (state_ff != ST_STANDBY) begin
      if (scl_rise && bit_cnt_ff < 4'(BITS_PER_BYTE)) begin
        shift_ff   <= {shift_ff[6:0], filt_ff[IN_SDA]}; // see R1, R2
        bit_cnt_ff <= bit_cnt_ff + 4'h1;
      end
      if (byte_done) begin
        ack_phase_ff <= 1'b1;
      end else if (scl_fall && ack_phase_ff) begin
        ack_phase_ff <= 1'b0; // see R2
        bit_cnt_ff   <= '0;
      end
    end
  end

  // Protocol state.
  always_ff @(posedge clock) begin
    if (!rst_b || !alive) begin
      state_ff      <= ST_STANDBY; // see R10
      aux_ff        <= 1'b0;
      read_dir_ff   <= 1'b0;
      addr_hi_ff    <= '0;
      acked_data_ff <= 1'b0;
    end else if (start_seen) begin
      state_ff      <= ST_DEV_ADDR; // see R4, R26
      acked_data_ff <= 1'b0;
    end else if (stop_seen) begin
      state_ff <= ST_STANDBY; // see R5
    end else if (byte_done) begin
      case (state_ff)
        ST_DEV_ADDR: begin
          if ((rx_byte[7:4] == TYPE_ARRAY || rx_byte[7:4] == TYPE_AUX) &&
              rx_byte[3:1] == filt_ff[IN_S0 +: 3]) begin // see R14, R15, R16
            aux_ff      <= (rx_byte[7:4] == TYPE_AUX);
            read_dir_ff <= rx_byte[0]; // see R17
            state_ff    <= ST_ADDR_HI; // see R19
          end else begin
            state_ff <= ST_STANDBY; // see R18
          end
        end
        ST_ADDR_HI: begin
          addr_hi_ff <= rx_byte; // see R19
          state_ff   <= ST_ADDR_LO;
        end
        ST_ADDR_LO: state_ff <= read_dir_ff ? ST_RD_DATA : ST_WR_DATA;
        ST_WR_DATA: begin
          if (data_ok) begin
            acked_data_ff <= 1'b1;
          end
        end
        default: state_ff <= state_ff;
      endcase
    end
  end

  // Word address and target latched after the low address byte.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      word_addr_ff  <= '0;
      target_ff     <= TGT_NONE;
      addr_valid_ff <= 1'b0;
    end else begin
      addr_valid_ff <= 1'b0;
      if (alive && byte_done && state_ff == ST_ADDR_LO) begin
        target_ff     <= decode_target(aux_ff, read_dir_ff, {addr_hi_ff, rx_byte});
        addr_valid_ff <= 1'b1;
        if (aux_ff) begin
          word_addr_ff <= {addr_hi_ff, rx_byte} &
                          ((addr_hi_ff[AUX_SEL_LSB-8 +: 2] == AUX_SERIAL) ? SERIAL_MASK
                                                                     : INFO_MASK); // see R21
        end else begin
          word_addr_ff <= {addr_hi_ff, rx_byte} & (HALF_SIZE ? HALF_MASK : ARRAY_MASK); // see R20
        end
      end
    end
  end

  // Acknowledge driver: pulled low from the fall after bit eight to the next fall.
  always_ff @(posedge clock) begin
    if (!rst_b || !alive) begin
      sda_oe_ff <= 1'b0;
    end else if (start_seen || stop_seen) begin
      sda_oe_ff <= 1'b0;
    end else if (byte_done) begin
      case (state_ff)
        ST_DEV_ADDR: sda_oe_ff <= (rx_byte[7:4] == TYPE_ARRAY || rx_byte[7:4] == TYPE_AUX) &&
                                  rx_byte[3:1] == filt_ff[IN_S0 +: 3]; // see R18, R1
        ST_ADDR_HI:  sda_oe_ff <= 1'b1; // see R19, R24
        ST_ADDR_LO:  sda_oe_ff <= 1'b1; // see R19, R24
        ST_WR_DATA:  sda_oe_ff <= data_ok;
        default:     sda_oe_ff <= 1'b0;
      endcase
    end else if (scl_fall && ack_phase_ff) begin
      sda_oe_ff <= 1'b0; // see R7
    end
  end

  // The line is open drain, so the driven level is always low.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      sda_o_ff <= 1'b0;
    end else begin
      sda_o_ff <= 1'b0;
    end
  end

  // Accepted data bytes are queued; a full buffer turns into a refused byte.
  assign push = alive && byte_done && state_ff == ST_WR_DATA && data_ok;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      push_ff      <= 1'b0;
      push_data_ff <= '0;
    end else begin
      push_ff      <= push;
      push_data_ff <= rx_byte;
    end
  end

  rx_byte_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock        (clock),
    .rst_b        (rst_b),
    .in_data      (push_data_ff),
    .in_valid     (push_ff),
    .in_ready     (fifo_in_ready),
    .out_data_ff  (rx_data_ff),
    .out_valid_ff (rx_valid_ff),
    .out_ready    (rx_ready)
  );

  // Write launch and standby indication.
  always_ff @(posedge clock) begin
    if (!rst_b || !alive) begin
      write_start_ff <= 1'b0;
      standby_ff     <= 1'b1; // see R8
    end else begin
      write_start_ff <= stop_seen && state_ff == ST_WR_DATA && acked_data_ff &&
                        !ack_phase_ff && bit_cnt_ff == 4'h1; // see R6
      if (start_seen) begin
        standby_ff <= 1'b0;
      end else if (stop_seen) begin
        standby_ff <= !(state_ff == ST_WR_DATA && acked_data_ff && bit_cnt_ff == 4'h1); // see R6
      end else if (op_done) begin
        standby_ff <= 1'b1; // see R8
      end else if (byte_done && state_ff == ST_DEV_ADDR && !(
                   (rx_byte[7:4] == TYPE_ARRAY || rx_byte[7:4] == TYPE_AUX) &&
                   rx_byte[3:1] == filt_ff[IN_S0 +: 3])) begin
        standby_ff <= 1'b1; // see R18
      end
    end
  end
endmodule // eeprom_front_end
`default_nettype wire

// ===== design/eeprom_front_pkg.sv
`default_nettype none
package eeprom_front_pkg;
  // Protocol figures.
  localparam int          BITS_PER_BYTE  = 8;
  localparam logic [3:0]  TYPE_ARRAY     = 4'hA;
  localparam logic [3:0]  TYPE_AUX       = 4'hB;
  localparam logic [1:0]  AUX_INFO_PAGE  = 2'h0;
  localparam logic [1:0]  AUX_SERIAL     = 2'h1;
  localparam logic [1:0]  AUX_FREEZE     = 2'h2;
  localparam int          AUX_SEL_LSB    = 9;
  localparam logic [15:0] ARRAY_MASK     = 16'h1FFF;
  localparam logic [15:0] HALF_MASK      = 16'h0FFF;
  localparam logic [15:0] INFO_MASK      = 16'h001F;
  localparam logic [15:0] SERIAL_MASK    = 16'h000F;
  localparam int          FIFO_DEPTH     = 32;
  // Startup wait the master must honour, in microseconds, and its cycle count.
  localparam int          CLOCK_HZ       = 10_000_000;
  localparam int          STARTUP_WAIT_US = 10_000;
  localparam int          STARTUP_CYCLES = STARTUP_WAIT_US * (CLOCK_HZ / 1_000_000);
  // Synchroniser vector layout and reset level.
  localparam int          IN_SCL = 0;
  localparam int          IN_SDA = 1;
  localparam int          IN_PG  = 2;
  localparam int          IN_BO  = 3;
  localparam int          IN_WP  = 4;
  localparam int          IN_S0  = 5;
  localparam int          IN_W   = 8;
  localparam logic [7:0]  SYNC_RST = 8'h03;

  typedef enum logic [2:0] {
    TGT_ARRAY, TGT_INFO_PAGE, TGT_LOCK_STATUS, TGT_FREEZE, TGT_SERIAL, TGT_NONE
  } target_t;

  typedef enum logic [2:0] {
    ST_STANDBY, ST_DEV_ADDR, ST_ADDR_HI, ST_ADDR_LO, ST_WR_DATA, ST_RD_DATA
  } state_t;
endpackage
`default_nettype wire

// ===== verification/bus_master_model.sv
`default_nettype none
module bus_master_model #(
  parameter int LOW  = 6,
  parameter int HIGH = 2
) (
  input  wire logic clock,
  input  wire logic sda_line,
  output var logic  scl,
  output var logic  sda
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Bits change only while the clock is low, one per 800 ns cycle, no gaps.
  task automatic put_bit(input logic b, output logic seen);
    sda <= b;
    hold(LOW - 1);
    scl <= 1'b1;
    hold(HIGH);
    seen = sda_line;
    scl <= 1'b0;
    hold(1);
  endtask
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(b[i], s);
    put_bit(1'b1, s);
    ack = ~s;
  endtask
  task automatic start();
    sda <= 1'b1;
    hold(LOW - 1);
    scl <= 1'b1;
    hold(4);
    sda <= 1'b0;
    hold(4);
    scl <= 1'b0;
    hold(1);
  endtask
  task automatic stop();
    sda <= 1'b0;
    hold(LOW - 1);
    scl <= 1'b1;
    hold(4);
    sda <= 1'b1;
    hold(6);
  endtask
  task automatic recover();
    logic s;
    start();
    repeat (9) put_bit(1'b1, s);
    start();
    stop();
  endtask
endmodule // bus_master_model
`default_nettype wire

// ===== verification/eeprom_front_end_tb.sv
`default_nettype none
module eeprom_front_end_tb
  import eeprom_front_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock, rst_b, power_good, brownout, scl, sda_m, sda_line, wp, op_done;
  logic        frozen, rx_ready, stall, sda_o, sda_oe, standby, wstart, avalid, rdir, rx_valid;
  logic [2:0]  strap;
  target_t     target;
  logic [15:0] waddr;
  logic [7:0]  rx_data;
  logic [7:0]  exp_q[$];
  int          fail_count, samples_checked, cycles, wcount, acount;
  // The line has a pull-up; the device only ever pulls it low.
  assign sda_line = sda_m & ~(sda_oe & ~sda_o);
  bus_master_model u_master (.clock(clock), .sda_line(sda_line), .scl(scl), .sda(sda_m));
  eeprom_front_end u_eeprom_front_end (
    .clock(clock), .rst_b(rst_b), .power_good(power_good), .brownout(brownout),
    .scl_i(scl), .sda_i(sda_line), .sda_o_ff(sda_o), .sda_oe_ff(sda_oe),
    .strap_addr_bit0(strap[0]), .strap_addr_bit1(strap[1]), .strap_addr_bit2(strap[2]),
    .write_protect(wp), .info_page_frozen(frozen), .op_done(op_done),
    .standby_ff(standby), .write_start_ff(wstart), .addr_valid_ff(avalid),
    .target_ff(target), .read_dir_ff(rdir), .word_addr_ff(waddr), .rx_data_ff(rx_data),
    .rx_valid_ff(rx_valid), .rx_ready(rx_ready));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      end_sim();
    end
    if (wstart) wcount++;
    if (avalid) acount++;
    if (rst_b && rx_valid && rx_ready) check(rx_data, exp_q.pop_front());
    rx_ready <= stall ? 1'b0 : 1'($urandom_range(1));
  end
  function automatic target_t exp_tgt(input logic [3:0] ty, input logic rd, input logic [1:0] s);
    if (ty == TYPE_ARRAY) return TGT_ARRAY;
    if (s == AUX_INFO_PAGE) return TGT_INFO_PAGE;
    return rd ? TGT_SERIAL : TGT_FREEZE;
  endfunction
  function automatic logic [15:0] exp_mask(input target_t t);
    if (t == TGT_ARRAY) return ARRAY_MASK;
    return (t == TGT_SERIAL) ? SERIAL_MASK : INFO_MASK;
  endfunction
  task automatic open(input logic [3:0] ty, input logic [2:0] ch, input logic rd, output logic a);
    u_master.start();
    u_master.put_byte({ty, ch, rd}, a);
  endtask
  task automatic word(input logic [3:0] ty, input logic rd, input logic [15:0] wa);
    logic    a1, a2;
    target_t t;
    int      a0;
    t = exp_tgt(ty, rd, wa[10:9]);
    a0 = acount;
    u_master.put_byte(wa[15:8], a1);
    u_master.put_byte(wa[7:0], a2);
    check({a1, a2}, 2'h3);
    check(target, t);
    check(rdir, rd);
    check(acount, a0 + 1);
    if (t != TGT_FREEZE) check(waddr, wa & exp_mask(t));
  endtask
  task automatic send_data(output logic a);
    logic [7:0] d;
    d = 8'($urandom);
    exp_q.push_back(d);
    u_master.put_byte(d, a);
    if (!a) void'(exp_q.pop_back());
  endtask
  task automatic close_frame();
    u_master.stop();
    repeat (4) @(posedge clock);
  endtask
  initial begin
    logic        a;
    logic        rd;
    logic [15:0] wa;
    int          n, w0, acks;
    {rst_b, power_good, brownout, wp, frozen, op_done, stall} = 7'h00;
    void'($urandom(40));
    strap <= 3'($urandom);
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    open(TYPE_ARRAY, strap, 1'b0, a);
    check(a, 1'b0);
    close_frame();
    power_good <= 1'b1;
    // The startup wait is shortened; the device holds no counter for it.
    repeat (20) @(posedge clock);
    u_master.recover();
    u_master.put_byte({TYPE_ARRAY, strap, 1'b0}, a);
    check(a, 1'b0);
    $display("test power done");
    for (int t = 0; t < 3; t++) begin
      wa = 16'($urandom);
      n = 1 + $urandom_range(3);
      w0 = wcount;
      open(TYPE_ARRAY, strap, 1'b0, a);
      check(a, 1'b1);
      word(TYPE_ARRAY, 1'b0, wa);
      repeat (n) begin
        send_data(a);
        check(a, 1'b1);
      end
      close_frame();
      check(wcount, w0 + 1);
      check(standby, 1'b0);
      op_done <= 1'b1;
      @(posedge clock);
      op_done <= 1'b0;
      repeat (2) @(posedge clock);
      check(standby, 1'b1);
    end
    $display("test array write done");
    open(TYPE_ARRAY, strap ^ 3'h1, 1'b0, a);
    check(a, 1'b0);
    check(standby, 1'b1);
    open(4'h9, strap, 1'b0, a);
    check(a, 1'b0);
    open(TYPE_ARRAY, strap, 1'b1, a);
    repeat (4) u_master.put_bit(1'b0, a);
    open(TYPE_ARRAY, strap, 1'b0, a);
    check(a, 1'b1);
    word(TYPE_ARRAY, 1'b0, 16'hFFFF);
    w0 = wcount;
    close_frame();
    check(wcount, w0);
    check(standby, 1'b1);
    $display("test refuse and restart done");
    for (int k = 0; k < 4; k++) begin
      rd = k[0];
      wa = 16'($urandom);
      wa[10:9] = k[1] ? (rd ? AUX_SERIAL : AUX_FREEZE) : AUX_INFO_PAGE;
      open(TYPE_AUX, strap, rd, a);
      check(a, 1'b1);
      word(TYPE_AUX, rd, wa);
      close_frame();
      check(standby, 1'b1);
    end
    $display("test aux targets done");
    for (int k = 0; k < 3; k++) begin
      wp     <= (k < 2);
      frozen <= (k == 2);
      open(k ? TYPE_AUX : TYPE_ARRAY, strap, 1'b0, a);
      check(a, 1'b1);
      word(k ? TYPE_AUX : TYPE_ARRAY, 1'b0, 16'h0000);
      send_data(a);
      check(a, 1'b0);
      close_frame();
    end
    {wp, frozen} <= 2'b00;
    brownout <= 1'b1;
    power_good <= 1'b0;
    repeat (10) @(posedge clock);
    open(TYPE_ARRAY, strap, 1'b0, a);
    check(a, 1'b0);
    close_frame();
    {brownout, power_good} <= 2'b01;
    repeat (20) @(posedge clock);
    $display("test protect and brownout done");
    stall <= 1'b1;
    acks = 0;
    open(TYPE_ARRAY, strap, 1'b0, a);
    word(TYPE_ARRAY, 1'b0, 16'h1234);
    for (int i = 0; i < FIFO_DEPTH + 6; i++) begin
      send_data(a);
      acks += int'(a);
    end
    check(16'(acks >= FIFO_DEPTH && acks < FIFO_DEPTH + 6), 16'h0001);
    close_frame();
    stall <= 1'b0;
    for (int i = 0; i < 2000 && exp_q.size() != 0; i++) @(posedge clock);
    check(16'(exp_q.size()), 16'h0000);
    $display("test fifo done");
    end_sim();
  end
endmodule // eeprom_front_end_tb
`default_nettype wire

// ===== verification/eeprom_front_properties.sv
`default_nettype none
module eeprom_front_properties
  import eeprom_front_pkg::*;
#(
  parameter bit HALF_SIZE = 1'b0
) (
  input wire logic        clock,
  input wire logic        rst_b,
  input wire logic        power_good,
  input wire logic        brownout,
  input wire logic        scl_i,
  input wire logic        sda_i,
  input wire logic        sda_o_ff,
  input wire logic        sda_oe_ff,
  input wire logic        strap_addr_bit0,
  input wire logic        strap_addr_bit1,
  input wire logic        strap_addr_bit2,
  input wire logic        write_protect,
  input wire logic        info_page_frozen,
  input wire logic        op_done,
  input wire logic        standby_ff,
  input wire logic        write_start_ff,
  input wire logic        addr_valid_ff,
  input wire target_t     target_ff,
  input wire logic        read_dir_ff,
  input wire logic [15:0] word_addr_ff,
  input wire logic [7:0]  rx_data_ff,
  input wire logic        rx_valid_ff,
  input wire logic        rx_ready
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic [15:0] array_mask;
  assign array_mask = HALF_SIZE ? HALF_MASK : ARRAY_MASK;
  open_drain_a: assert property (sda_o_ff == 1'b0)
    else $error("data pin driven high");
  ack_edge_a: assert property ($changed(sda_oe_ff) |-> !scl_i)
    else $error("ack moved while clock high");
  ack_hold_a: assert property ($rose(sda_oe_ff) |-> sda_oe_ff [*6])
    else $error("ack released early");
  power_quiet_a: assert property (!power_good [*8] |-> !sda_oe_ff)
    else $error("answer without power");
  brown_quiet_a: assert property (brownout [*8] |-> !sda_oe_ff)
    else $error("answer during brownout");
  write_pulse_a: assert property (write_start_ff |-> !standby_ff ##1 !write_start_ff)
    else $error("bad write launch pulse");
  done_standby_a: assert property (op_done |=> standby_ff)
    else $error("no standby after completion");
  array_mask_a: assert property (addr_valid_ff && target_ff == TGT_ARRAY |->
    (word_addr_ff & ~array_mask) == 16'h0000) else $error("array address not masked");
  aux_mask_a: assert property (addr_valid_ff && target_ff == TGT_SERIAL |->
    (word_addr_ff & ~SERIAL_MASK) == 16'h0000) else $error("serial address not masked");
  fifo_hold_a: assert property (rx_valid_ff && !rx_ready |=> rx_valid_ff && $stable(rx_data_ff))
    else $error("stalled byte changed");
endmodule // eeprom_front_properties
bind eeprom_front_end eeprom_front_properties #(.HALF_SIZE(HALF_SIZE)) u_props (
  .clock(clock), .rst_b(rst_b), .power_good(power_good), .brownout(brownout),
  .scl_i(scl_i), .sda_i(sda_i), .sda_o_ff(sda_o_ff), .sda_oe_ff(sda_oe_ff),
  .strap_addr_bit0(strap_addr_bit0), .strap_addr_bit1(strap_addr_bit1),
  .strap_addr_bit2(strap_addr_bit2), .write_protect(write_protect),
  .info_page_frozen(info_page_frozen), .op_done(op_done), .standby_ff(standby_ff),
  .write_start_ff(write_start_ff), .addr_valid_ff(addr_valid_ff), .target_ff(target_ff),
  .read_dir_ff(read_dir_ff), .word_addr_ff(word_addr_ff), .rx_data_ff(rx_data_ff),
  .rx_valid_ff(rx_valid_ff), .rx_ready(rx_ready)
);
`default_nettype wire
